// >>> hdl/lpt_threshold_irq.sv
`timescale 1ns/1ps
`default_nettype none
`include "lpt_regs.svh"

// Operation
// - Low threshold word at 8Ah/8Bh
// - High threshold word at 8Ch/8Dh
// - Status register 8Eh, four flags
// - Bit 1 flags low threshold crossing
// - Bit 0 flags high threshold crossing
// - Flags are sticky until cleared
// - Writing one clears only that flag
// - Interrupt pin low while any flag set
// - Modulator timing register at 8Fh fields
// - Timing register resets to one
// - Ambient IR register at 90h is read only
module lpt_threshold_irq
    import lpt_pkg::*;
#(
    parameter int DATA_W = 16,
    parameter int PERSIST_W = 8
) (
    input wire logic i_core_clk,
    input wire logic i_arst_n,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    output logic [7:0] o_reg_rdata,
    input wire logic i_prox_new,
    input wire logic [DATA_W-1:0] i_prox_result,
    input wire logic i_als_new,
    input wire logic [DATA_W-1:0] i_als_result,
    input wire logic [7:0] i_amb_ir_level,
    output logic [7:0] o_int_ctrl,
    output logic [7:0] o_emitter_timing,
    output logic o_int_n
);

    // Only the documented widths are served; the count of 128 needs eight bits
    if (DATA_W != 16) begin : g_bad_data_w
        $error("DATA_W must be 16");
    end
    if (PERSIST_W < 8) begin : g_bad_persist_w
        $error("PERSIST_W must hold 128");
    end

    logic [7:0] int_ctrl_ff, nxt_int_ctrl;
    logic [15:0] low_limit_ff, nxt_low_limit;
    logic [15:0] high_limit_ff, nxt_high_limit;
    logic [3:0] flags_ff, nxt_flags;
    logic [7:0] timing_ff, nxt_timing;
    logic [7:0] amb_ir_ff, nxt_amb_ir;
    logic [PERSIST_W-1:0] below_cnt_ff, nxt_below_cnt;
    logic [PERSIST_W-1:0] above_cnt_ff, nxt_above_cnt;
    logic [7:0] rdata_ff, nxt_rdata;
    lpt_acc_t acc;

    // Consecutive count needed: 1 shl code
    function automatic logic [PERSIST_W-1:0] persist_need(input logic [2:0] code);
        persist_need = PERSIST_W'(1) << code;
    endfunction

    // Saturating persistence counter step
    function automatic logic [PERSIST_W-1:0] cnt_step(
        input logic [PERSIST_W-1:0] cnt,
        input logic hit
    );
        if (!hit) begin
            cnt_step = '0;
        end else if (&cnt) begin
            cnt_step = cnt;
        end else begin
            cnt_step = cnt + PERSIST_W'(1);
        end
    endfunction

    assign acc = i_reg_wr ? LPT_ACC_WR : (i_reg_rd ? LPT_ACC_RD : LPT_ACC_IDLE);

    // Configuration registers written by the host
    always_comb begin
        nxt_int_ctrl = int_ctrl_ff;
        nxt_low_limit = low_limit_ff;
        nxt_high_limit = high_limit_ff;
        nxt_timing = timing_ff;
        if (acc == LPT_ACC_WR) begin
            unique case (i_reg_addr)
                `LPT_ADDR_INT_CTRL: begin
                    nxt_int_ctrl = i_reg_wdata;
                end
                `LPT_ADDR_LOW_HI: begin
                    nxt_low_limit[15:8] = i_reg_wdata;
                end
                `LPT_ADDR_LOW_LO: begin
                    nxt_low_limit[7:0] = i_reg_wdata;
                end
                `LPT_ADDR_HIGH_HI: begin
                    nxt_high_limit[15:8] = i_reg_wdata;
                end
                `LPT_ADDR_HIGH_LO: begin
                    nxt_high_limit[7:0] = i_reg_wdata;
                end
                `LPT_ADDR_TIMING: begin
                    nxt_timing = i_reg_wdata;
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            int_ctrl_ff <= `LPT_RST_ZERO;
            low_limit_ff <= 16'h0000;
            high_limit_ff <= 16'h0000;
            timing_ff <= `LPT_RST_TIMING;
        end else begin
            int_ctrl_ff <= nxt_int_ctrl;
            low_limit_ff <= nxt_low_limit;
            high_limit_ff <= nxt_high_limit;
            timing_ff <= nxt_timing;
        end
    end

    // Ambient IR level tracks the engine; host writes are ignored
    always_comb begin
        nxt_amb_ir = i_amb_ir_level;
    end

    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            amb_ir_ff <= `LPT_RST_ZERO;
        end else begin
            amb_ir_ff <= nxt_amb_ir;
        end
    end

    // Persistence counters and sticky event flags
    logic thr_new;
    logic [15:0] sel_result;
    logic below_hit, above_hit;
    logic [3:0] set_vec, clr_vec;
    logic [PERSIST_W-1:0] need;

    always_comb begin
        sel_result = int_ctrl_ff[`LPT_CTL_THR_SEL] ? i_als_result : i_prox_result;
        thr_new = int_ctrl_ff[`LPT_CTL_THR_SEL] ? i_als_new : i_prox_new;
        need = persist_need(int_ctrl_ff[`LPT_CTL_CNT_MSB:`LPT_CTL_CNT_LSB]);
        nxt_below_cnt = below_cnt_ff;
        nxt_above_cnt = above_cnt_ff;
        below_hit = 1'b0;
        above_hit = 1'b0;
        // Counts only advance on a fresh result of the selected source
        if (thr_new) begin
            nxt_below_cnt = cnt_step(below_cnt_ff, sel_result < low_limit_ff);
            nxt_above_cnt = cnt_step(above_cnt_ff, sel_result > high_limit_ff);
            below_hit = (nxt_below_cnt == need);
            above_hit = (nxt_above_cnt == need);
        end
        set_vec = '0;
        set_vec[`LPT_BIT_PROX_RDY] = i_prox_new & int_ctrl_ff[`LPT_CTL_PROX_EN];
        set_vec[`LPT_BIT_ALS_RDY] = i_als_new & int_ctrl_ff[`LPT_CTL_ALS_EN];
        set_vec[`LPT_BIT_BELOW] = below_hit & int_ctrl_ff[`LPT_CTL_THR_EN];
        set_vec[`LPT_BIT_ABOVE] = above_hit & int_ctrl_ff[`LPT_CTL_THR_EN];
        clr_vec = '0;
        if (acc == LPT_ACC_WR && i_reg_addr == `LPT_ADDR_FLAGS) begin
            clr_vec = i_reg_wdata[3:0];
        end
        // A set in the clearing cycle wins so no event is lost
        nxt_flags = (flags_ff & ~clr_vec) | set_vec;
    end

    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            below_cnt_ff <= '0;
            above_cnt_ff <= '0;
            flags_ff <= 4'h0;
        end else begin
            below_cnt_ff <= nxt_below_cnt;
            above_cnt_ff <= nxt_above_cnt;
            flags_ff <= nxt_flags;
        end
    end

    // Read data registered, so it shows one cycle after the read strobe
    always_comb begin
        nxt_rdata = rdata_ff;
        if (acc == LPT_ACC_RD) begin
            unique case (i_reg_addr)
                `LPT_ADDR_INT_CTRL: nxt_rdata = int_ctrl_ff;
                `LPT_ADDR_LOW_HI: nxt_rdata = low_limit_ff[15:8];
                `LPT_ADDR_LOW_LO: nxt_rdata = low_limit_ff[7:0];
                `LPT_ADDR_HIGH_HI: nxt_rdata = high_limit_ff[15:8];
                `LPT_ADDR_HIGH_LO: nxt_rdata = high_limit_ff[7:0];
                `LPT_ADDR_FLAGS: nxt_rdata = {4'h0, flags_ff};
                `LPT_ADDR_TIMING: nxt_rdata = timing_ff;
                `LPT_ADDR_AMB_IR: nxt_rdata = amb_ir_ff;
                default: nxt_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rdata_ff <= 8'h00;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    // Outputs
    assign o_reg_rdata = rdata_ff;
    assign o_int_ctrl = int_ctrl_ff;
    assign o_emitter_timing = timing_ff;
    assign o_int_n = ~(|flags_ff);

endmodule // lpt_threshold_irq

`default_nettype wire

// >>> hdl/lpt_regs.svh
`ifndef LPT_REGS_SVH
`define LPT_REGS_SVH
// Register addresses
`define LPT_ADDR_INT_CTRL      8'h89
`define LPT_ADDR_LOW_HI        8'h8a
`define LPT_ADDR_LOW_LO        8'h8b
`define LPT_ADDR_HIGH_HI       8'h8c
`define LPT_ADDR_HIGH_LO       8'h8d
`define LPT_ADDR_FLAGS         8'h8e
`define LPT_ADDR_TIMING        8'h8f
`define LPT_ADDR_AMB_IR        8'h90
// Event flag bit positions
`define LPT_BIT_PROX_RDY       3
`define LPT_BIT_ALS_RDY        2
`define LPT_BIT_BELOW          1
`define LPT_BIT_ABOVE          0
// Interrupt control bit positions
`define LPT_CTL_CNT_MSB        7
`define LPT_CTL_CNT_LSB        5
`define LPT_CTL_PROX_EN        3
`define LPT_CTL_ALS_EN         2
`define LPT_CTL_THR_EN         1
`define LPT_CTL_THR_SEL        0
// Reset values
`define LPT_RST_TIMING         8'h01
`define LPT_RST_ZERO           8'h00
`endif

// >>> hdl/lpt_pkg.sv
package lpt_pkg;
    // Register bus access kind
    typedef enum logic [1:0] {
        LPT_ACC_IDLE = 2'b00,
        LPT_ACC_WR = 2'b01,
        LPT_ACC_RD = 2'b10
    } lpt_acc_t;
endpackage

// >>> sim/lpt_threshold_irq_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module lpt_threshold_irq_monitor (
    input wire logic i_core_clk,
    input wire logic i_arst_n,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic [7:0] o_reg_rdata,
    input wire logic i_prox_new,
    input wire logic i_als_new,
    input wire logic [7:0] o_int_ctrl,
    input wire logic [7:0] o_emitter_timing,
    input wire logic o_int_n
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_arst_n);
    // Write to the flag register, and a full clear with no event racing it
    sequence flag_wr;
        i_reg_wr && i_reg_addr == 8'h8e;
    endsequence
    sequence clear_all;
        flag_wr ##0 (i_reg_wdata[3:0] == 4'hf && !i_prox_new && !i_als_new);
    endsequence
    timing_hold_a: assert property (!(i_reg_wr && i_reg_addr == 8'h8f) |=>
        $stable(o_emitter_timing)) else $error("timing register changed unasked");
    clear_all_a: assert property (clear_all |=> o_int_n)
        else $error("interrupt still low after full clear");
    ready_int_a: assert property (i_prox_new && o_int_ctrl[3] |=> !o_int_n)
        else $error("enabled ready event did not raise interrupt");
    int_sticky_a: assert property (!o_int_n && !(i_reg_wr && i_reg_addr == 8'h8e)
        |=> !o_int_n) else $error("flag dropped without clear");
    int_rise_a: assert property ($rose(o_int_n) |-> $past(i_reg_wr)
        && $past(i_reg_addr) == 8'h8e) else $error("interrupt released without clear");
    int_fall_a: assert property ($fell(o_int_n) |-> $past(i_prox_new || i_als_new))
        else $error("interrupt without event");
    flag_read_a: assert property (i_reg_rd && !i_reg_wr && i_reg_addr == 8'h8e |=>
        o_reg_rdata[7:4] == 4'h0 && ((o_reg_rdata[3:0] != 4'h0) == !$past(o_int_n)))
        else $error("flag readback disagrees with interrupt");
    rdata_hold_a: assert property (!i_reg_rd |=> $stable(o_reg_rdata))
        else $error("read data changed without read");
endmodule // lpt_threshold_irq_monitor
bind lpt_threshold_irq lpt_threshold_irq_monitor lpt_threshold_irq_monitor_inst (.i_core_clk,
    .i_arst_n, .i_reg_wr, .i_reg_rd, .i_reg_addr, .i_reg_wdata, .o_reg_rdata, .i_prox_new,
    .i_als_new, .o_int_ctrl, .o_emitter_timing, .o_int_n);
`default_nettype wire

// >>> sim/lpt_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module lpt_host_model (
    input wire logic i_core_clk,
    input wire logic [7:0] i_reg_rdata,
    output logic o_reg_wr,
    output logic o_reg_rd,
    output logic [7:0] o_reg_addr,
    output logic [7:0] o_reg_wdata
);
    // Idle bus at time zero
    initial {o_reg_wr, o_reg_rd, o_reg_addr, o_reg_wdata} = 18'h0;
    // One write pulse; never aimed at 90h, a one clears a flag
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_core_clk);
        {o_reg_wr, o_reg_addr, o_reg_wdata} = {1'b1, a, d};
        @(negedge i_core_clk);
        {o_reg_wr, o_reg_addr, o_reg_wdata} = {1'b0, ~a, ~d}; // Released bus shows junk
    endtask
    // One read pulse; data is registered on the read edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge i_core_clk);
        {o_reg_rd, o_reg_addr} = {1'b1, a};
        @(negedge i_core_clk);
        {o_reg_rd, o_reg_addr} = {1'b0, ~a};
        d = i_reg_rdata;
    endtask
endmodule // lpt_host_model
`default_nettype wire

// >>> sim/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk = 1'b0, arst_n = 1'b0, wr, rd, pnew = 1'b0, anew = 1'b0, int_n;
    logic [7:0] addr, wdata, rdata, seen, ctrl_out, tim_out;
    logic [15:0] pres = 16'h0, ares = 16'h0;
    int fail_count = 0, checked = 0, cyc = 0;
    // Address, write data, expected readback; 90h is read only
    logic [23:0] rows [10] = '{24'h8a0101, 24'h8b0000, 24'h8c8080, 24'h8d0000, 24'h8fe7e7,
        24'h8f0101, 24'h91ff00, 24'h90006b, 24'h8e0f00, 24'h890e0e};
    lpt_threshold_irq lpt_threshold_irq_inst (.i_core_clk(clk), .i_arst_n(arst_n),
        .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_addr(addr), .i_reg_wdata(wdata),
        .o_reg_rdata(rdata), .i_prox_new(pnew), .i_prox_result(pres), .i_als_new(anew),
        .i_als_result(ares), .i_amb_ir_level(8'h6b), .o_int_ctrl(ctrl_out),
        .o_emitter_timing(tim_out), .o_int_n(int_n));
    lpt_host_model host_inst (.i_core_clk(clk), .i_reg_rdata(rdata), .o_reg_wr(wr),
        .o_reg_rd(rd), .o_reg_addr(addr), .o_reg_wdata(wdata));
    // Clock and hang guard
    always #12.5 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 2000) begin
            fail_count++;
            results();
        end
    end
    task automatic results();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        checked++;
        if (s !== e) begin
            fail_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        host_inst.rd(a, seen);
        chk(seen, e);
    endtask
    // One measurement result pulse, proximity or ambient
    task automatic ev(input logic p, input logic [15:0] v);
        @(negedge clk);
        {pnew, anew, pres, ares} = {p, !p, v, v};
        @(negedge clk);
        {pnew, anew} = 2'b00;
    endtask
    initial begin
        repeat (10) @(negedge clk);
        arst_n = 1'b1;
        rc(8'h8f, 8'h01);
        foreach (rows[k]) begin
            if (rows[k][23:16] != 8'h90) host_inst.wr(rows[k][23:16], rows[k][15:8]);
            rc(rows[k][23:16], rows[k][7:0]);
        end
        chk(ctrl_out, 8'h0e);
        ev(1'b1, 16'h0050);
        rc(8'h8e, 8'h0a);
        chk({7'h0, int_n}, 8'h00);
        host_inst.wr(8'h8e, 8'h02);
        rc(8'h8e, 8'h08);
        host_inst.wr(8'h8e, 8'h08);
        chk({7'h0, int_n}, 8'h01);
        ev(1'b0, 16'hffff);
        rc(8'h8e, 8'h04);
        ev(1'b1, 16'h9000);
        rc(8'h8e, 8'h0d);
        host_inst.wr(8'h8e, 8'h0f);
        host_inst.wr(8'h89, 8'h22);
        // An in-range result restarts the count left over from the last crossing
        ev(1'b1, 16'h0500);
        ev(1'b1, 16'h9000);
        rc(8'h8e, 8'h00);
        ev(1'b1, 16'h9000);
        ev(1'b1, 16'h0500);
        rc(8'h8e, 8'h01);
        // Source select on ambient: proximity results no longer compared
        host_inst.wr(8'h8e, 8'h0f);
        host_inst.wr(8'h89, 8'h03);
        chk(ctrl_out, 8'h03);
        ev(1'b1, 16'h0050);
        rc(8'h8e, 8'h00);
        ev(1'b0, 16'h0050);
        rc(8'h8e, 8'h02);
        host_inst.wr(8'h8f, 8'h55);
        chk(tim_out, 8'h55);
        @(negedge clk) arst_n = 1'b0;
        @(negedge clk);
        chk({tim_out[7:1], int_n}, 8'h01);
        chk(tim_out, 8'h01);
        chk(ctrl_out, 8'h00);
        chk(rdata, 8'h00);
        arst_n = 1'b1;
        rc(8'h8e, 8'h00);
        results();
    end
endmodule // testbench
`default_nettype wire
